// *** hdl/pcgpio_pkg.sv ***
// Purpose: constants shared by the pin configuration block
// Assumes: byte-wide register port of the host interface
// Notes:   offsets are the register addresses
package pcgpio_pkg;
   localparam int unsigned PCG_NPINS        = 8;
   localparam logic [6:0]  PCG_ADDR_PIN_EN  = 7'h44;
   localparam logic [6:0]  PCG_ADDR_PIN_OUT = 7'h45;
   localparam logic [6:0]  PCG_ADDR_PIN_IN  = 7'h46;
   localparam logic [6:0]  PCG_ADDR_SIGSEL  = 7'h47;
   localparam logic [7:0]  PCG_RST_BYTE     = 8'h00;
   localparam int unsigned PCG_BIT_SIGNAL_INPUT_PIN    = 7;
   localparam int unsigned PCG_BIT_CLOCK_OUTPUT_PIN   = 6;
   localparam int unsigned PCG_BIT_FAST     = 7;
   localparam int unsigned PCG_SCAN_LSB     = 0;
   localparam int unsigned PCG_SCAN_MSB     = 3;
   localparam logic [3:0]  PCG_SCAN_MASK    = 4'hF;
   localparam logic [7:0]  PCG_SIGSEL_WMASK = 8'h8F;
   typedef enum logic [3:0] {
      PCG_SRC_HIZ0   = 4'h0,
      PCG_SRC_HIZ1   = 4'h1,
      PCG_SRC_LOW    = 4'h2,
      PCG_SRC_HIGH   = 4'h3,
      PCG_SRC_TXENV  = 4'h4,
      PCG_SRC_TXACT  = 4'h5,
      PCG_SRC_SECMOD = 4'h6,
      PCG_SRC_RXENV  = 4'h7,
      PCG_SRC_RXACT  = 4'h8,
      PCG_SRC_RXBIT  = 4'h9
   } pcg_src_t;
endpackage

// *** hdl/pcgpio_sync.sv ***
// Purpose: two-flop synchroniser for pin input buffers
// Assumes: pins are asynchronous to clk_i
// Notes:   first stage read only by the second
`timescale 1ns/1ns
module pcgpio_sync (
   input  wire logic    clk_i,
   input  wire logic    rstn_i,
   pcgpio_sync_if.syncer sif
);
   import pcgpio_pkg::*;
   typedef struct packed {
      logic [7:0] meta;
      logic [7:0] stab;
   } pcg_sync_st_t;
   pcg_sync_st_t st_ff, nxt_st;
   always_comb begin
      nxt_st      = st_ff;
      nxt_st.meta = sif.raw;
      nxt_st.stab = st_ff.meta;
   end
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   assign sif.sync = st_ff.stab;
endmodule // pcgpio_sync

// *** hdl/pcgpio_sync_if.sv ***
// Purpose: carries raw and synchronised pin levels between modules
// Assumes: one clock
// Notes:   none
`timescale 1ns/1ns
interface pcgpio_sync_if;
   logic [7:0] raw;
   logic [7:0] sync;
   modport syncer (input raw, output sync);
   modport user   (output raw, input sync);
endinterface // pcgpio_sync_if

// *** hdl/pcgpio_top.sv ***
// Purpose: pin configuration and signal-output routing
// Assumes: byte register port, synchronous active-low reset
// Notes:   register values reset to zero
// How it works
// RULE1 - enable bit 7 drives signal input pin
// RULE2 - enable bit 6 replaces clock output
// RULE3 - bits 5,4 drive interface select pins
// RULE4 - bits 3..0 drive scan pins TCK..TDO
// RULE5 - scan strap ignores scan enable bits
// RULE6 - output register holds driven pin levels
// RULE7 - input register returns synchronised pin levels
// RULE8 - select bit 7 sets fast pads
// RULE9 - codes 0,1 hi-z, 2 low, 3 high
// RULE10 - codes 4,5,6 route tx and secure
// RULE11 - code 7 routes receive envelope
// RULE12 - code 8 rx active, 9 rx bits
// RULE13 - codes above 9 leave pin hi-z
// RULE14 - cleared enable keeps driver off, except bit 6 drives clock
`timescale 1ns/1ns
module pcgpio_top (
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic [6:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   input  wire logic       scan_active_i,
   input  wire logic       clock_func_i,
   input  wire logic       tx_envelope_i,
   input  wire logic       tx_active_i,
   input  wire logic       secure_module_generic_signal_i,
   input  wire logic       rx_envelope_i,
   input  wire logic       rx_active_i,
   input  wire logic       rx_bit_i,
   input  wire logic [7:0] pin_in_i,
   output logic      [7:0] pin_out_o,
   output logic      [7:0] pin_oe_o,
   output logic            scan_owns_pins_o,
   output logic            signal_output_pin_o,
   output logic            signal_output_pin_oe_o,
   output logic            fast_pad_mode_o
);
   import pcgpio_pkg::*;
   typedef struct packed {
      logic [7:0] pin_output_enable;
      logic [7:0] pin_output_value;
      logic [7:0] signal_output_select;
      logic       scan_strap;
      logic       strap_taken;
      logic [7:0] rdata;
      logic       sig_val;
      logic       sig_oe;
   } pcg_st_t;
   pcg_st_t st_ff, nxt_st;
   pcgpio_sync_if sif ();
   logic [7:0] eff_en;
   logic [3:0] src;
   assign sif.raw = pin_in_i;
   pcgpio_sync u_sync (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .sif    (sif.syncer)
   );
   always_comb begin
      // strap level caught once after reset release, a clocked capture
      eff_en = st_ff.pin_output_enable;
      if (st_ff.scan_strap) begin
         eff_en[PCG_SCAN_MSB:PCG_SCAN_LSB] = '0; // RULE5
      end
   end
   always_comb begin
      nxt_st = st_ff;
      src    = '0;
      if (!st_ff.strap_taken) begin
         nxt_st.scan_strap  = scan_active_i;
         nxt_st.strap_taken = 1'b1;
      end
      if (reg_wr_i) begin
         case (reg_addr_i)
            PCG_ADDR_PIN_EN:  nxt_st.pin_output_enable = reg_wdata_i;
            PCG_ADDR_PIN_OUT: nxt_st.pin_output_value = reg_wdata_i; // RULE6
            // reserved bits 6..4 dropped, they read as zero
            PCG_ADDR_SIGSEL:  nxt_st.signal_output_select = reg_wdata_i & PCG_SIGSEL_WMASK;
            default: ;
         endcase
      end
      case (reg_addr_i)
         PCG_ADDR_PIN_EN:  nxt_st.rdata = st_ff.pin_output_enable;
         PCG_ADDR_PIN_OUT: nxt_st.rdata = st_ff.pin_output_value;
         PCG_ADDR_PIN_IN:  nxt_st.rdata = sif.sync; // RULE7
         PCG_ADDR_SIGSEL:  nxt_st.rdata = st_ff.signal_output_select;
         default:          nxt_st.rdata = PCG_RST_BYTE;
      endcase
      src = st_ff.signal_output_select[3:0];
      case (pcg_src_t'(src))
         PCG_SRC_HIZ0, PCG_SRC_HIZ1: begin
            nxt_st.sig_oe  = 1'b0; // RULE9
            nxt_st.sig_val = 1'b0;
         end
         PCG_SRC_LOW: begin
            nxt_st.sig_oe  = 1'b1; // RULE9
            nxt_st.sig_val = 1'b0;
         end
         PCG_SRC_HIGH: begin
            nxt_st.sig_oe  = 1'b1; // RULE9
            nxt_st.sig_val = 1'b1;
         end
         PCG_SRC_TXENV: begin
            nxt_st.sig_oe  = 1'b1; // RULE10
            nxt_st.sig_val = tx_envelope_i;
         end
         PCG_SRC_TXACT: begin
            nxt_st.sig_oe  = 1'b1; // RULE10
            nxt_st.sig_val = tx_active_i;
         end
         PCG_SRC_SECMOD: begin
            nxt_st.sig_oe  = 1'b1; // RULE10
            nxt_st.sig_val = secure_module_generic_signal_i;
         end
         PCG_SRC_RXENV: begin
            // meaningful only for the 106 kBd type A protocol
            nxt_st.sig_oe  = 1'b1; // RULE11
            nxt_st.sig_val = rx_envelope_i;
         end
         PCG_SRC_RXACT: begin
            nxt_st.sig_oe  = 1'b1; // RULE12
            nxt_st.sig_val = rx_active_i;
         end
         PCG_SRC_RXBIT: begin
            nxt_st.sig_oe  = 1'b1; // RULE12
            nxt_st.sig_val = rx_bit_i;
         end
         default: begin
            nxt_st.sig_oe  = 1'b0; // RULE13
            nxt_st.sig_val = 1'b0;
         end
      endcase
   end
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
   always_comb begin
      pin_oe_o  = eff_en; // RULE1 RULE3 RULE4 RULE14
      pin_out_o = st_ff.pin_output_value & eff_en; // RULE14
      // clock function only while the pin is not taken for i/o
      if (!eff_en[PCG_BIT_CLOCK_OUTPUT_PIN]) begin
         pin_oe_o[PCG_BIT_CLOCK_OUTPUT_PIN]  = 1'b1; // RULE2
         pin_out_o[PCG_BIT_CLOCK_OUTPUT_PIN] = clock_func_i;
      end
   end
   assign reg_rdata_o            = st_ff.rdata;
   assign scan_owns_pins_o       = st_ff.scan_strap; // RULE5
   assign signal_output_pin_o    = st_ff.sig_val;
   assign signal_output_pin_oe_o = st_ff.sig_oe;
   assign fast_pad_mode_o        = st_ff.signal_output_select[PCG_BIT_FAST]; // RULE8
endmodule // pcgpio_top

// *** test/pcgpio_board.sv ***
// Purpose: board circuitry on the eight general pins
// Assumes: board drives every pin the block releases
// Notes:   no pulls modelled
`timescale 1ns/1ns
module pcgpio_board (
   input  wire logic [7:0] pin_out_i, pin_oe_i, ext_level_i,
   output logic      [7:0] pin_in_o
);
   // board never fights a pin the block drives
   assign pin_in_o = (pin_out_i & pin_oe_i) | (ext_level_i & ~pin_oe_i);
endmodule // pcgpio_board

// *** test/pcgpio_chk.sv ***
// Purpose: port assertions of the pin configuration block
// Assumes: one clock, sync active-low reset
// Notes:   watches a subset of top ports
`timescale 1ns/1ns
module pcgpio_chk (
   input wire logic       clk_i, rstn_i, reg_wr_i, clock_func_i, tx_envelope_i, scan_owns_pins_o,
   input wire logic       signal_output_pin_o, signal_output_pin_oe_o, fast_pad_mode_o,
   input wire logic [6:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i, pin_out_o, pin_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   logic       w44, w47;
   logic [3:0] wc;
   assign w44 = reg_wr_i && reg_addr_i == 7'h44;
   assign w47 = reg_wr_i && reg_addr_i == 7'h47;
   assign wc = reg_wdata_i[3:0];
   // strap not yet latched on the first edge
   a_en_drive: assert property (w44 && $past(rstn_i) && !scan_owns_pins_o
      |=> pin_oe_o == ($past(reg_wdata_i) | 8'h40)) else $error("enable");
   a_scan_kept: assert property (scan_owns_pins_o |-> pin_oe_o[3:0] == 4'h0) else $error("scan");
   a_off_quiet: assert property ((pin_out_o & ~pin_oe_o) == 8'h00) else $error("gated");
   a_clk_pass: assert property (w44 && !reg_wdata_i[6] ##1 !w44
      |=> pin_out_o[6] == clock_func_i) else $error("clock pin");
   a_pad_fast: assert property (w47 |=> fast_pad_mode_o == $past(reg_wdata_i[7])) else $error("pad");
   a_sig_hiz: assert property (w47 && (wc < 4'h2 || wc > 4'h9) ##1 !w47
      |=> !signal_output_pin_oe_o) else $error("hiz");
   a_sig_level: assert property (w47 && wc[3:1] == 3'h1 ##1 !w47
      |=> signal_output_pin_oe_o && signal_output_pin_o == $past(reg_wdata_i[0], 2)) else $error("level");
   a_sig_tx: assert property (w47 && wc == 4'h4 ##1 !w47
      |=> signal_output_pin_oe_o && signal_output_pin_o == $past(tx_envelope_i)) else $error("tx");
endmodule // pcgpio_chk
bind pcgpio_top pcgpio_chk u_chk (.*);

// *** test/test_pin_config_gpio_signal_output_pin.sv ***
// Purpose: self-checking bench of the pin configuration block
// Assumes: 250 MHz clock, inputs driven 1 ns after the edge
// Notes:   board model feeds the pin inputs
`timescale 1ns/1ns
module test_pin_config_gpio_signal_output_pin;
   import pcgpio_pkg::*;
   logic clk_i = 0, rstn_i = 0, reg_wr_i = 0, scan_active_i = 0, clock_func_i = 0, tx_envelope_i = 0;
   logic tx_active_i = 0, secure_module_generic_signal_i = 0, rx_envelope_i = 0, rx_active_i = 0, rx_bit_i = 0;
   logic [6:0] reg_addr_i = 7'h00;
   logic [7:0] reg_wdata_i = 8'h00, ext = 8'h00, pin_in_i, reg_rdata_o, pin_out_o, pin_oe_o;
   logic scan_owns_pins_o, signal_output_pin_o, signal_output_pin_oe_o, fast_pad_mode_o;
   int   failures = 0, checks = 0;
   always #2 clk_i = ~clk_i;
   pcgpio_top dut (.*);
   pcgpio_board board (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .ext_level_i(ext), .pin_in_o(pin_in_i));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) failures++;
      if (seen !== exp) $display("[ERR] %0t seen %h want %h", $time, seen, exp);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
      @(posedge clk_i) #1 reg_wr_i = 0;
      // idle edge keeps back-to-back strobes apart
      @(posedge clk_i) #1;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      reg_addr_i = a;
      @(posedge clk_i) #1 chk(reg_rdata_o, e);
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_regs();
      chk(pin_oe_o, 8'h40);
      wr(PCG_ADDR_PIN_EN, 8'hFF);
      chk(pin_oe_o, 8'hFF);
      wr(PCG_ADDR_PIN_OUT, 8'hA5);
      wr(PCG_ADDR_PIN_IN, 8'h11);
      rd(PCG_ADDR_PIN_OUT, 8'hA5);
      wr(PCG_ADDR_PIN_EN, 8'h81);
      chk(pin_out_o, 8'h81);
      rd(7'h50, 8'h00);
      $display("regs end");
   endtask
   task automatic t_pin();
      {clock_func_i, ext} = {1'b1, 8'h3C};
      wr(PCG_ADDR_PIN_EN, 8'h00);
      repeat (3) @(posedge clk_i) #1;
      rd(PCG_ADDR_PIN_IN, 8'h7C);
      // distinct bits per pin catch a swapped value order
      wr(PCG_ADDR_PIN_OUT, 8'h35);
      wr(PCG_ADDR_PIN_EN, 8'h3C);
      chk(pin_oe_o, 8'h7C);
      chk(pin_out_o, 8'h74);
      repeat (3) @(posedge clk_i) #1;
      rd(PCG_ADDR_PIN_IN, 8'h74);
      $display("pin end");
   endtask
   task automatic t_sel(input logic [5:0] s, input logic [7:0] hi);
      logic [1:0] e;
      logic [1:0] g;
      {rx_bit_i, rx_active_i, rx_envelope_i, secure_module_generic_signal_i, tx_active_i, tx_envelope_i} = s;
      for (int c = 0; c < 16; c++) begin
         e = (c == 2 || c == 3) ? {1'b1, c[0]} : (c > 3 && c < 10) ? {1'b1, s[c - 4]} : 2'b00;
         wr(PCG_ADDR_SIGSEL, hi | 8'(c));
         @(posedge clk_i) #1;
         g = {signal_output_pin_oe_o, signal_output_pin_o & signal_output_pin_oe_o};
         chk({6'h00, g}, {6'h00, e});
         chk({7'h00, fast_pad_mode_o}, {7'h00, hi[7]});
         rd(PCG_ADDR_SIGSEL, (hi & 8'h8F) | 8'(c));
      end
      $display("sel end");
   endtask
   task automatic t_scan();
      {rstn_i, scan_active_i} = 2'b01;
      repeat (2) @(posedge clk_i) #1;
      rstn_i = 1;
      @(posedge clk_i) #1 wr(PCG_ADDR_PIN_EN, 8'hFF);
      chk(pin_oe_o, 8'hF0);
      chk({7'h00, scan_owns_pins_o}, 8'h01);
      $display("scan end");
   endtask
   initial begin
      repeat (2) @(posedge clk_i) #1;
      rstn_i = 1;
      @(posedge clk_i) #1 t_regs();
      t_pin();
      t_sel(6'h15, 8'hF0);
      t_sel(6'h2A, 8'h70);
      t_scan();
      conclude();
   end
   initial begin
      #9000 failures++;
      conclude();
   end
endmodule // test_pin_config_gpio_signal_output_pin
